// *** cacc_comma_detect.sv ***
`timescale 1ns/1ns
module cacc_comma_detect
  import cacc_pkg::*;
(
  input  wire logic [9:0] window,
  input  wire logic       sym8,
  input  cacc_sel_e       sel,
  input  wire logic [9:0] custom,
  output logic            hit
);

  logic pos;
  logic neg;
  logic cus;

  // newest bit sits at window[0]
  always_comb begin
    if (sym8) begin
      pos = window[7:0] == COMMA8_POS;
      neg = window[7:0] == COMMA8_NEG;
      cus = window[7:0] == custom[7:0];
    end else begin
      pos = window == COMMA10_POS;
      neg = window == COMMA10_NEG;
      cus = window == custom;
    end
    case (sel)
      SEL_PLUS:  hit = pos;
      SEL_MINUS: hit = neg;
      SEL_BOTH:  hit = pos | neg;
      default:   hit = cus;
    endcase
  end

endmodule

// *** cacc_elastic_mem.sv ***
`timescale 1ns/1ns
module cacc_elastic_mem
  import cacc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_idx,
  input  wire logic [39:0] wr_data,
  input  wire logic [3:0]  rd_idx,
  input  wire logic [39:0] cc_pat,
  input  wire logic [39:0] wmask,
  output logic [39:0]      rd_data,
  output logic [15:0]      cc_hit
);

  typedef struct packed {
    logic [DEPTH-1:0][39:0] mem;
  } cacc_mem_s;

  cacc_mem_s st;
  cacc_mem_s next_st;

  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.mem[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // sequences recognised on the stored words, at the read side
  always_comb begin
    rd_data = st.mem[rd_idx];
    for (int i = 0; i < DEPTH; i++) begin
      cc_hit[i] = (st.mem[i] & wmask) == (cc_pat & wmask);
    end
  end

endmodule

// *** cacc_pkg.sv ***
package cacc_pkg;

  typedef enum logic [1:0] {SEL_PLUS, SEL_MINUS, SEL_BOTH, SEL_CUSTOM} cacc_sel_e;

  // control register layout, bit 0 first: align_en, align_sel, sym8, width_sel,
  // boundary_sel, cc_en, cc_len2, correction_repeat_wait
  typedef struct packed {
    logic [3:0] correction_repeat_wait;
    logic       cc_len2;
    logic       cc_en;
    logic [1:0] boundary_sel;
    logic [1:0] width_sel;
    logic       sym8;
    cacc_sel_e  align_sel;
    logic       align_en;
  } cacc_ctrl_s;

  localparam int         CTRL_W   = 14;
  localparam cacc_ctrl_s CTRL_RST = '{4'h0, 1'b0, 1'b1, 2'h0, 2'h1, 1'b0, SEL_BOTH, 1'b1};

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CUSTOM = 8'h04;
  localparam logic [7:0] ADDR_CCLO   = 8'h08;
  localparam logic [7:0] ADDR_CCHI   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;
  localparam logic [7:0] ADDR_FILL   = 8'h18;
  localparam logic [7:0] ADDR_COUNT  = 8'h1C;

  localparam int ST_REALIGN = 0;
  localparam int ST_REPEAT  = 1;
  localparam int ST_SKIP    = 2;
  localparam int ST_OVER    = 3;
  localparam int ST_UNDER   = 4;
  localparam int ST_W       = 5;

  localparam logic [9:0]  COMMA10_POS = 10'h0FA;
  localparam logic [9:0]  COMMA10_NEG = 10'h305;
  localparam logic [7:0]  COMMA8_POS  = 8'hF6;
  localparam logic [7:0]  COMMA8_NEG  = 8'h28;
  localparam logic [9:0]  CUSTOM_RST  = 10'h17C;
  localparam logic [39:0] CCPAT_RST   = 40'h0;

  localparam int         DEPTH     = 16;
  localparam logic [4:0] FILL_FULL = 5'h10;
  localparam logic [4:0] FILL_LOW  = 5'h06;
  localparam logic [4:0] FILL_HIGH = 5'h0A;

  function automatic logic [5:0] cacc_width(input logic [1:0] sel);
    case (sel)
      2'h0:    return 6'h10;
      2'h1:    return 6'h14;
      2'h2:    return 6'h20;
      default: return 6'h28;
    endcase
  endfunction

  function automatic logic [5:0] cacc_mod(input logic [5:0] a, input logic [5:0] b);
    return a % b;
  endfunction

  function automatic logic [39:0] cacc_mask(input logic [5:0] w);
    return {40{1'b1}} >> (6'h28 - w);
  endfunction

endpackage

// *** cacc_rx_align.sv ***
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module cacc_rx_align
  import cacc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        recovered_rx_clk,
  input  wire logic        rx_serial,
  input  wire logic        user_read_clk,
  input  wire logic        align_slip_req,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic [39:0]      rx_data,
  output logic             rx_valid,
  output logic             rx_realign,
  output logic             irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0]      sync_rclk;
    logic [1:0]      sync_uclk;
    logic [1:0]      sync_bit;
    logic [1:0]      sync_slip;
    logic            rclk_d;
    logic            uclk_d;
    logic            slip_d;
    logic [39:0]     sh;
    logic [5:0]      wcnt;
    logic            slip_pend;
    logic            word_wr;
    logic [39:0]     word_data;
    logic            realign_pend;
    logic [4:0]      wptr;
    logic [4:0]      rptr;
    logic [3:0]      wait_cnt;
    logic [39:0]     rx_data;
    logic            rx_valid;
    logic            rx_realign;
    cacc_ctrl_s      ctrl;
    logic [9:0]      custom;
    logic [39:0]     ccpat;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [7:0]      realign_cnt;
    logic [7:0]      repeat_cnt;
    logic [7:0]      skip_cnt;
    logic [31:0]     rdata;
  } cacc_state_s;

  cacc_state_s st;
  cacc_state_s next_st;

  logic [9:0]      window;
  logic            comma_hit;
  logic [3:0]      rd_idx;
  logic [39:0]     rd_data;
  logic [15:0]     cc_hit;
  logic [39:0]     wmask;
  logic            wr_en;
  logic [4:0]      fill;
  logic [5:0]      w_bits;
  logic [5:0]      s_bits;
  logic [5:0]      g_bits;
  logic [4:0]      len;
  logic [4:0]      rp;
  logic [ST_W-1:0] set_ev;

  // ==========================================================
  // helpers
  function automatic logic seq_at(input logic [15:0] cc, input logic [4:0] p,
                                  input logic len2);
    logic [4:0] q;
    q = p + 5'h01;
    return cc[p[3:0]] & (~len2 | cc[q[3:0]]);
  endfunction

  function automatic logic seq_end(input logic [15:0] cc, input logic [4:0] p,
                                   input logic len2);
    logic [4:0] q;
    q = p - 5'h01;
    return cc[p[3:0]] & (~len2 | cc[q[3:0]]);
  endfunction

  function automatic logic [7:0] bump(input logic [7:0] c);
    return (c == 8'hFF) ? c : c + 8'h01;
  endfunction

  // ==========================================================
  // datapath geometry
  always_comb begin
    w_bits = cacc_width(st.ctrl.width_sel);
    s_bits = st.ctrl.sym8 ? 6'h08 : 6'h0A;
    case (st.ctrl.boundary_sel)
      2'h0:    g_bits = s_bits;
      2'h1:    g_bits = s_bits << 1;
      default: g_bits = s_bits << 2;
    endcase
    if (g_bits > w_bits) begin
      g_bits = w_bits;
    end
    wmask  = cacc_mask(w_bits);
    len    = st.ctrl.cc_len2 ? 5'h02 : 5'h01;
    fill   = st.wptr - st.rptr;
    window = {st.sh[8:0], st.sync_bit[1]};
    wr_en  = st.word_wr & (fill != FILL_FULL);
  end

  cacc_comma_detect u_comma (
    .window (window),
    .sym8   (st.ctrl.sym8),
    .sel    (st.ctrl.align_sel),
    .custom (st.custom),
    .hit    (comma_hit)
  );

  cacc_elastic_mem u_mem (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .clk_en  (clk_en),
    .wr_en   (wr_en),
    .wr_idx  (st.wptr[3:0]),
    .wr_data (st.word_data),
    .rd_idx  (rd_idx),
    .cc_pat  (st.ccpat),
    .wmask   (wmask),
    .rd_data (rd_data),
    .cc_hit  (cc_hit)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic       rclk_rise;
    logic       uclk_rise;
    logic       slip_rise;
    logic [5:0] cnt;
    logic       ev_realign;
    logic       ev_repeat;
    logic       ev_skip;
    logic       ev_over;
    logic       ev_under;
    logic       corr;
    logic [3:0] reload;
    rclk_rise  = 1'b0;
    uclk_rise  = 1'b0;
    slip_rise  = 1'b0;
    cnt        = 6'h00;
    ev_realign = 1'b0;
    ev_repeat  = 1'b0;
    ev_skip    = 1'b0;
    ev_over    = 1'b0;
    ev_under   = 1'b0;
    corr       = 1'b0;
    reload     = 4'h0;
    rp         = st.rptr;
    next_st    = st;

    // pin synchronisers and edge finders
    next_st.sync_rclk = {st.sync_rclk[0], recovered_rx_clk};
    next_st.sync_uclk = {st.sync_uclk[0], user_read_clk};
    next_st.sync_bit  = {st.sync_bit[0], rx_serial};
    next_st.sync_slip = {st.sync_slip[0], align_slip_req};
    next_st.rclk_d    = st.sync_rclk[1];
    next_st.uclk_d    = st.sync_uclk[1];
    next_st.slip_d    = st.sync_slip[1];
    rclk_rise = st.sync_rclk[1] & ~st.rclk_d;
    uclk_rise = st.sync_uclk[1] & ~st.uclk_d;
    slip_rise = st.sync_slip[1] & ~st.slip_d;
    next_st.word_wr  = 1'b0;
    next_st.rx_valid = 1'b0;
    if (slip_rise) begin
      next_st.slip_pend = 1'b1;
    end

    // ========================================================
    // bit assembly and alignment, recovered clock side
    if (rclk_rise) begin
      next_st.sh = {st.sh[38:0], st.sync_bit[1]};
      cnt = st.wcnt + 6'h01;
      if (st.slip_pend) begin
        cnt = st.wcnt;
        next_st.slip_pend = slip_rise;
        ev_realign = 1'b1;
      end else if (st.ctrl.align_en && comma_hit &&
                   cacc_mod(cnt, g_bits) != cacc_mod(s_bits, g_bits)) begin
        cnt = s_bits;
        ev_realign = 1'b1;
      end
      if (cnt >= w_bits) begin
        next_st.word_wr   = 1'b1;
        next_st.word_data = next_st.sh & wmask;
        cnt = 6'h00;
      end
      next_st.wcnt = cnt;
    end

    // ========================================================
    // buffer write
    if (st.word_wr) begin
      if (fill == FILL_FULL) begin
        ev_over = 1'b1;
      end else begin
        next_st.wptr = st.wptr + 5'h01;
      end
    end

    // ========================================================
    // buffer read and clock correction, user clock side
    if (uclk_rise) begin
      next_st.rx_realign   = st.realign_pend;
      next_st.realign_pend = 1'b0;
      if (st.wait_cnt != 4'h0) begin
        next_st.wait_cnt = st.wait_cnt - 4'h1;
      end
      if (fill == 5'h00) begin
        ev_under = 1'b1;
      end else begin
        if (st.ctrl.cc_en && fill > FILL_HIGH && st.wait_cnt == 4'h0 &&
            fill > len && seq_at(cc_hit, st.rptr, st.ctrl.cc_len2)) begin
          rp = st.rptr + len;
          ev_skip = 1'b1;
          if (st.ctrl.correction_repeat_wait == 4'h0 && fill > (len << 1) &&
              seq_at(cc_hit, rp, st.ctrl.cc_len2)) begin
            rp = rp + len;
          end
          next_st.rptr = rp + 5'h01;
        end else if (st.ctrl.cc_en && fill < FILL_LOW && st.wait_cnt == 4'h0 &&
                     seq_end(cc_hit, st.rptr, st.ctrl.cc_len2)) begin
          next_st.rptr = st.rptr + 5'h01 - len;
          ev_repeat = 1'b1;
        end else begin
          next_st.rptr = st.rptr + 5'h01;
        end
        corr = ev_skip | ev_repeat;
        next_st.rx_data  = rd_data;
        next_st.rx_valid = 1'b1;
      end
      if (corr) begin
        reload = st.ctrl.correction_repeat_wait;
        if (reload == 4'h0 && !st.ctrl.cc_len2) begin
          reload = 4'h1;
        end
        next_st.wait_cnt = reload;
      end
    end
    if (ev_realign) begin
      next_st.realign_pend = 1'b1;
      next_st.realign_cnt  = bump(st.realign_cnt);
    end
    if (ev_repeat) begin
      next_st.repeat_cnt = bump(st.repeat_cnt);
    end
    if (ev_skip) begin
      next_st.skip_cnt = bump(st.skip_cnt);
    end

    // ========================================================
    // register port
    set_ev = '0;
    set_ev[ST_REALIGN] = ev_realign;
    set_ev[ST_REPEAT]  = ev_repeat;
    set_ev[ST_SKIP]    = ev_skip;
    set_ev[ST_OVER]    = ev_over;
    set_ev[ST_UNDER]   = ev_under;
    next_st.status = st.status | set_ev;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL:   next_st.ctrl = cacc_ctrl_s'(reg_wdata[CTRL_W-1:0]);
        ADDR_CUSTOM: next_st.custom = reg_wdata[9:0];
        ADDR_CCLO:   next_st.ccpat[31:0] = reg_wdata;
        ADDR_CCHI:   next_st.ccpat[39:32] = reg_wdata[7:0];
        ADDR_STATUS: next_st.status = (st.status & ~reg_wdata[ST_W-1:0]) | set_ev;
        ADDR_MASK:   next_st.mask = reg_wdata[ST_W-1:0];
        ADDR_COUNT: begin
          next_st.realign_cnt = 8'h00;
          next_st.repeat_cnt  = 8'h00;
          next_st.skip_cnt    = 8'h00;
        end
        default: ;
      endcase
    end
    next_st.rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL:   next_st.rdata = {18'h0, st.ctrl};
        ADDR_CUSTOM: next_st.rdata = {22'h0, st.custom};
        ADDR_CCLO:   next_st.rdata = st.ccpat[31:0];
        ADDR_CCHI:   next_st.rdata = {24'h0, st.ccpat[39:32]};
        ADDR_STATUS: next_st.rdata = {27'h0, st.status};
        ADDR_MASK:   next_st.rdata = {27'h0, st.mask};
        ADDR_FILL:   next_st.rdata = {16'h0, 2'h0, st.wcnt, 3'h0, fill};
        ADDR_COUNT:  next_st.rdata = {8'h0, st.skip_cnt, st.repeat_cnt, st.realign_cnt};
        default:     next_st.rdata = 32'h0;
      endcase
    end
  end

  // read index follows a skip so the first kept word leaves at once
  assign rd_idx = rp[3:0];

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st        <= '0;
      st.ctrl   <= CTRL_RST;
      st.custom <= CUSTOM_RST;
      st.ccpat  <= CCPAT_RST;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata  = st.rdata;
  assign rx_data    = st.rx_data;
  assign rx_valid   = st.rx_valid;
  assign rx_realign = st.rx_realign;
  assign irq        = |(st.status & st.mask);

endmodule

// *** cacc_rx_align_checker.sv ***
`timescale 1ns/1ns
module cacc_checker
  import cacc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        user_read_clk,
  input wire logic        align_slip_req,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [39:0] rx_data,
  input wire logic        rx_valid,
  input wire logic        rx_realign,
  input wire logic        irq
);
  // ==========
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // user pin rose a few cycles back
  sequence s_user_rise;
    $past(user_read_clk, 2) && !$past(user_read_clk, 6);
  endsequence

  sequence s_bad_addr;
    reg_rd && (reg_addr > 8'h1C || reg_addr[1:0] != 2'h0);
  endsequence

  a_valid_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("valid longer than one cycle");
  a_valid_cause: assert property (rx_valid |-> s_user_rise)
    else $error("word without user clock edge");
  a_data_hold: assert property ($past(nrst) && !rx_valid |-> $stable(rx_data))
    else $error("data moved without a read");
  a_realign_step: assert property ($past(nrst) && $changed(rx_realign) |-> s_user_rise)
    else $error("realign changed off a user edge");
  a_slip_report: assert property ($rose(align_slip_req) |-> ##[1:400] rx_realign)
    else $error("slip not reported");
  a_rdata_idle: assert property ($past(nrst) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_rdata_hole: assert property (s_bad_addr |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($rose(nrst) |-> !rx_valid && !rx_realign && !irq)
    else $error("outputs busy after reset");
endmodule

bind cacc_rx_align cacc_checker u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .user_read_clk(user_read_clk),
  .align_slip_req(align_slip_req), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_realign(rx_realign), .irq(irq)
);

// *** cacc_tx_model.sv ***
`timescale 1ns/1ns
module cacc_tx_model
  import cacc_pkg::*;
#(
  parameter logic [19:0] WORD = 20'h0
)
(
  output logic recovered_rx_clk,
  output logic rx_serial
);
  // ==========
  // serial source, msb first, 320 ns bits
  initial begin
    recovered_rx_clk = 1'b0;
    rx_serial = 1'b0;
    #7;
    // the same word repeats back to back, with no gaps
    forever begin
      for (int i = 19; i >= 0; i--) begin
        rx_serial = WORD[i];
        #160 recovered_rx_clk = 1'b1;
        #160 recovered_rx_clk = 1'b0;
      end
    end
  end
endmodule

// *** test_cacc_rx_align.sv ***
`timescale 1ns/1ns
module test_cacc_rx_align
  import cacc_pkg::*;
;
  localparam logic [19:0] pat = {COMMA10_POS, 10'h2AA};
  logic        ref_clk;
  logic        nrst;
  logic        user_read_clk;
  logic        align_slip_req;
  logic        reg_wr;
  logic        reg_rd;
  logic        recovered_rx_clk;
  logic        rx_serial;
  logic        rx_valid;
  logic        rx_realign;
  logic        irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic [39:0] rx_data;
  logic [39:0] w;
  int          fail_count;
  int          checks;
  int          uhalf;
  int          ucnt;

  cacc_rx_align dut (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(1'b1), .recovered_rx_clk(recovered_rx_clk),
    .rx_serial(rx_serial), .user_read_clk(user_read_clk), .align_slip_req(align_slip_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_realign(rx_realign), .irq(irq)
  );
  cacc_tx_model #(.WORD(pat)) u_tx (
    .recovered_rx_clk(recovered_rx_clk),
    .rx_serial(rx_serial)
  );

  // ==========
  // clocks
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (ucnt == 0) begin
      user_read_clk <= ~user_read_clk;
      ucnt <= uhalf;
    end else begin
      ucnt <= ucnt - 1;
    end
  end

  // ==========
  // helpers
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // k-th next word handed to the user side
  task automatic gw(input int k, output logic [39:0] v);
    repeat (k) begin
      v = 'x;
      for (int n = 0; n < 400; n++) begin
        @(posedge ref_clk);
        #1;
        if (rx_valid === 1'b1) begin
          v = rx_data;
          break;
        end
      end
    end
  endtask

  task automatic slip();
    @(posedge ref_clk);
    align_slip_req <= 1'b1;
    repeat (20) @(posedge ref_clk);
    align_slip_req <= 1'b0;
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq, e);
  endtask

  // ==========
  // scenarios
  task automatic t_regs();
    rd(ADDR_CTRL, d);
    chk(d, 32'h115);
    rd(ADDR_CUSTOM, d);
    chk(d, 32'h17C);
    rd(ADDR_MASK, d);
    chk(d, 32'h0);
    wr(8'h20, 32'hFFFF);
    rd(8'h20, d);
    chk(d, 32'h0);
  endtask

  task automatic t_align();
    gw(6, w);
    chk(w, {20'h0, pat});
    rd(ADDR_STATUS, d);
    chk(d[ST_REALIGN], 1'b1);
  endtask

  task automatic t_sel();
    cacc_sel_e s[4] = '{SEL_MINUS, SEL_PLUS, SEL_CUSTOM, SEL_BOTH};
    wr(ADDR_CUSTOM, {22'h0, COMMA10_POS});
    foreach (s[i]) begin
      wr(ADDR_CTRL, 32'h111 | (32'(s[i]) << 1));
      slip();
      gw(4, w);
      chk(w, {20'h0, (s[i] == SEL_MINUS) ? {pat[18:0], pat[19]} : pat});
    end
  endtask

  task automatic t_off();
    wr(ADDR_CTRL, 32'h114);
    slip();
    gw(4, w);
    chk(w, {20'h0, pat[18:0], pat[19]});
    slip();
    gw(4, w);
    chk(w, {20'h0, pat[17:0], pat[19:18]});
    wr(ADDR_CTRL, 32'h115);
    gw(4, w);
    chk(w, {20'h0, pat});
  endtask

  // 40-bit path on a two-symbol boundary: word opens on the comma
  task automatic t_wide();
    wr(ADDR_CTRL, 32'h175);
    gw(6, w);
    chk(w, {pat, pat});
    chk(w[39:30], COMMA10_POS);
    wr(ADDR_CTRL, 32'h115);
    gw(4, w);
    chk(w, {20'h0, pat});
  endtask

  task automatic t_irq();
    wr(ADDR_MASK, 32'h0);
    slip();
    gw(4, w);
    rd(ADDR_STATUS, d);
    chk(d[ST_REALIGN], 1'b1);
    irq_is(1'b0);
    wr(ADDR_MASK, 32'h1);
    irq_is(1'b1);
    wr(ADDR_STATUS, 32'h1);
    irq_is(1'b0);
  endtask

  task automatic t_cc();
    wr(ADDR_CCLO, {12'h0, pat});
    wr(ADDR_CCHI, 32'h0);
    uhalf = 99;
    gw(80, w);
    rd(ADDR_STATUS, d);
    chk(d[3:2], 2'b01);
    rd(ADDR_FILL, d);
    chk(d[4:0] >= 5'h5 && d[4:0] <= 5'hB, 1'b1);
    wr(ADDR_STATUS, 32'h1F);
    uhalf = 64;
    gw(60, w);
    chk(w, {20'h0, pat});
    rd(ADDR_STATUS, d);
    chk({d[4], d[1]}, 2'b01);
    rd(ADDR_FILL, d);
    chk(d[4:0] >= 5'h5 && d[4:0] <= 5'hB, 1'b1);
  endtask

  task automatic conclude();
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #3_000_000;
    fail_count++;
    conclude();
  end

  initial begin
    fail_count = 0;
    checks = 0;
    uhalf = 79;
    ucnt = 0;
    nrst = 1'b0;
    user_read_clk = 1'b0;
    align_slip_req = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_align();
    t_sel();
    t_off();
    t_wide();
    t_irq();
    t_cc();
    conclude();
  end
endmodule
